// file: rtl/pst_pkg.sv
// Package: register map, field layout and reset values of the steering block
package pst_pkg;

  // Register offsets on the Wishbone bus (byte addresses, one word each)
  localparam logic [4:0] ADDR_CCP_CONTROL      = 5'h00;
  localparam logic [4:0] ADDR_AUTO_SHUTDOWN    = 5'h04;
  localparam logic [4:0] ADDR_TIMER2_PERIOD    = 5'h08;
  localparam logic [4:0] ADDR_STEERING_CONTROL = 5'h0C;
  localparam logic [4:0] ADDR_RESTART_DELAY    = 5'h10;
  localparam logic [4:0] ADDR_TIMER2_CONTROL   = 5'h14;
  localparam logic [4:0] ADDR_TIMER2_COUNT     = 5'h18;

  // Reset values
  localparam logic [7:0] RST_CCP_CONTROL      = 8'h00;
  localparam logic [7:0] RST_AUTO_SHUTDOWN    = 8'h00;
  localparam logic [7:0] RST_TIMER2_PERIOD    = 8'hFF;
  localparam logic [7:0] RST_STEERING_CONTROL = 8'h01;
  localparam logic [7:0] RST_RESTART_DELAY    = 8'h00;
  localparam logic [7:0] RST_TIMER2_CONTROL   = 8'h00;
  localparam logic [7:0] RST_TIMER2_COUNT     = 8'h00;

  // Implemented-bit masks; other bits read as zero
  localparam logic [7:0] MASK_STEERING_CONTROL = 8'h1F;
  localparam logic [7:0] MASK_TIMER2_CONTROL   = 8'h7F;

  // Field positions
  localparam int STEER_SYNC_BIT    = 4;
  localparam int MODE_LSB          = 0;
  localparam int CONFIG_LSB        = 6;
  localparam int SHUTDOWN_FLAG_BIT = 7;
  localparam int TIMER2_COUNT_ON_BIT       = 2;
  localparam int TIMER2_COUNT_PRESC_LSB    = 0;
  localparam int RESTART_EN_BIT    = 7;

  // Field codes
  localparam logic [1:0] MODE_PWM_HI   = 2'h3;
  localparam logic [1:0] CONFIG_SINGLE = 2'h0;

  // Steering update state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_PENDING = 2'b10
  } pst_state_t;

endpackage

// file: rtl/pst_timer2.sv
// Timer2 counter: period match and prescale, marks the start of each PWM period
`timescale 1ns/1ns
module pst_timer2
  import pst_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] presc_sel_i,
  input  wire logic [7:0] period_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  output logic      [7:0] count_o,
  output logic            period_start_o
);

  logic [3:0] presc;
  logic [3:0] next_presc;
  logic [7:0] next_count;
  logic       next_start;
  logic [3:0] presc_last;

  // Prescale of 1, 4 or 16 counts per timer step
  always_comb begin
    case (presc_sel_i)
      2'h0:    presc_last = 4'h0;
      2'h1:    presc_last = 4'h3;
      default: presc_last = 4'hF;
    endcase
  end

  // Counter restarts on period match; that restart opens a new PWM period
  always_comb begin
    next_presc = presc;
    next_count = count_o;
    next_start = 1'b0;
    if (load_i) begin
      next_count = load_val_i;
      next_presc = 4'h0;
    end else if (run_i) begin
      if (presc >= presc_last) begin
        next_presc = 4'h0;
        if (count_o == period_i) begin
          next_count = 8'h00;
          next_start = 1'b1;
        end else begin
          next_count = count_o + 8'h01;
        end
      end else begin
        next_presc = presc + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc          <= 4'h0;
      count_o        <= RST_TIMER2_COUNT;
      period_start_o <= 1'b0;
    end else begin
      presc          <= next_presc;
      count_o        <= next_count;
      period_start_o <= next_start;
    end
  end

endmodule

// file: rtl/pst_pin_mux.sv
// Per-pin output stage: steer, polarity and shutdown state for four pins
`timescale 1ns/1ns
module pst_pin_mux
  import pst_pkg::*;
#(
  parameter int PINS = 4
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            pwm_i,
  input  wire logic [PINS-1:0] steer_i,
  input  wire logic [PINS-1:0] invert_i,
  input  wire logic            shutdown_i,
  input  wire logic [PINS-1:0] shut_level_i,
  input  wire logic [PINS-1:0] shut_tri_i,
  input  wire logic [PINS-1:0] port_data_i,
  output logic      [PINS-1:0] pin_o,
  output logic      [PINS-1:0] pin_drv_o
);

  logic [PINS-1:0] next_pin;
  logic [PINS-1:0] next_drv;

  // One slice per pin; shutdown only touches steered pins
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : g_pin
      always_comb begin
        if (!steer_i[g]) begin
          next_pin[g] = port_data_i[g];                  // R06
          next_drv[g] = 1'b0;
        end else if (shutdown_i) begin
          next_pin[g] = shut_level_i[g];                 // R09
          next_drv[g] = !shut_tri_i[g];
        end else begin
          next_pin[g] = pwm_i ^ invert_i[g];             // R08
          next_drv[g] = 1'b1;                            // R06
        end
      end
    end
  endgenerate

  // Registered outputs keep pins glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o     <= '0;
      pin_drv_o <= '0;
    end else begin
      pin_o     <= next_pin;
      pin_drv_o <= next_drv;
    end
  end

endmodule

// file: rtl/pst_steering.sv
// Top: pulse steering block with Wishbone registers, Timer2 and pin stage
//
// Operation
// R01 - With sync select clear, a written steering value applies after the write.
// R02 - Immediate updates ignore the PWM cycle; a truncated pulse may appear.
// R03 - With sync select set, a written value waits for the next PWM period.
// R04 - Synchronised steering yields only whole PWM waveforms on a pin.
// R05 - Unimplemented register bits read back as zero.
// R06 - A steered pin carries the PWM; an unsteered pin returns to port use.
// R07 - Steering works only in PWM mode (11) with single output config (00).
// R08 - Mode field low bits set polarity of steered outputs.
// R09 - Auto-shutdown forces only the currently steered pins to shutdown state.
// R10 - In sync mode the latest written value is pending until period restart; a synced write in the restart cycle itself is not applied.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module pst_steering
  import pst_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone classic slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [4:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic            ack_o,
  // Modulated waveform from the duty generator
  input  wire logic       pwm_i,
  // Shutdown request from the auto-shutdown sources (pin, async)
  input  wire logic       shutdown_req_i,
  // Port latch values used when a pin is not steered
  input  wire logic [3:0] port_data_i,
  // Output pins
  output logic            pwm_out_a_o,
  output logic            pwm_out_b_o,
  output logic            pwm_out_c_o,
  output logic            pwm_out_d_o,
  output logic      [3:0] pin_drv_o,
  output logic            period_start_o,
  output logic            steer_active_o
);

  // Register storage
  logic [7:0] ccp_control;
  logic [7:0] auto_shutdown_control;
  logic [7:0] timer2_period;
  logic [7:0] steering_control;
  logic [7:0] pwm_restart_delay_control;
  logic [7:0] timer2_control;
  logic [7:0] next_ccp_control;
  logic [7:0] next_auto_shutdown_control;
  logic [7:0] next_timer2_period;
  logic [7:0] next_steering_control;
  logic [7:0] next_pwm_restart_delay_control;
  logic [7:0] next_timer2_control;

  // Steering state
  pst_state_t state;
  pst_state_t next_state;
  logic [3:0] active_steer;
  logic [3:0] next_active_steer;

  // Shutdown input synchroniser and latch
  logic       shut_meta;
  logic       shut_sync;
  logic       shutdown;
  logic       next_shutdown;

  logic       ack;
  logic       next_ack;
  logic [31:0] next_dat;
  logic       wr;
  logic       wr_steer;
  logic       wr_timer2_count;
  logic [7:0] timer2_count_count;
  logic       period_start;
  logic       steer_enable;
  logic [1:0] mode_field;
  logic [3:0] pin_vec;

  assign wr       = cyc_i && stb_i && we_i && !ack && sel_i[0];
  assign wr_steer = wr && (adr_i == ADDR_STEERING_CONTROL);
  assign wr_timer2_count  = wr && (adr_i == ADDR_TIMER2_COUNT);

  // Steering only in PWM mode with single output configuration
  assign steer_enable = (ccp_control[3:2] == MODE_PWM_HI) &&
                        (ccp_control[CONFIG_LSB +: 2] == CONFIG_SINGLE); // R07
  assign mode_field   = ccp_control[MODE_LSB +: 2];

  // Two flops before the shutdown pin is looked at
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_meta <= 1'b0;
      shut_sync <= 1'b0;
    end else begin
      shut_meta <= shutdown_req_i;
      shut_sync <= shut_meta;
    end
  end

  // Shutdown flag: set by the event, set wins over software clear;
  // auto restart clears it at a period start once the event is gone
  always_comb begin
    next_shutdown = shutdown;
    if (wr && adr_i == ADDR_AUTO_SHUTDOWN && !dat_i[SHUTDOWN_FLAG_BIT]) begin
      next_shutdown = 1'b0;
    end
    if (pwm_restart_delay_control[RESTART_EN_BIT] && period_start && !shut_sync) begin
      next_shutdown = 1'b0;
    end
    if (shut_sync) begin
      next_shutdown = 1'b1;
    end
  end

  // Register writes, one byte lane; no access takes effect twice
  always_comb begin
    next_ccp_control               = ccp_control;
    next_auto_shutdown_control     = auto_shutdown_control;
    next_timer2_period             = timer2_period;
    next_steering_control          = steering_control;
    next_pwm_restart_delay_control = pwm_restart_delay_control;
    next_timer2_control            = timer2_control;
    if (wr) begin
      case (adr_i)
        ADDR_CCP_CONTROL:      next_ccp_control = dat_i[7:0];
        ADDR_AUTO_SHUTDOWN:    next_auto_shutdown_control = {1'b0, dat_i[6:0]};
        ADDR_TIMER2_PERIOD:    next_timer2_period = dat_i[7:0];
        ADDR_STEERING_CONTROL: next_steering_control = dat_i[7:0] & MASK_STEERING_CONTROL;
        ADDR_RESTART_DELAY:    next_pwm_restart_delay_control = dat_i[7:0];
        ADDR_TIMER2_CONTROL:   next_timer2_control = dat_i[7:0] & MASK_TIMER2_CONTROL;
        default:               next_ccp_control = ccp_control;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccp_control               <= RST_CCP_CONTROL;
      auto_shutdown_control     <= RST_AUTO_SHUTDOWN;
      timer2_period             <= RST_TIMER2_PERIOD;
      steering_control          <= RST_STEERING_CONTROL;
      pwm_restart_delay_control <= RST_RESTART_DELAY;
      timer2_control            <= RST_TIMER2_CONTROL;
      shutdown                  <= 1'b0;
    end else begin
      ccp_control               <= next_ccp_control;
      auto_shutdown_control     <= next_auto_shutdown_control;
      timer2_period             <= next_timer2_period;
      steering_control          <= next_steering_control;
      pwm_restart_delay_control <= next_pwm_restart_delay_control;
      timer2_control            <= next_timer2_control;
      shutdown                  <= next_shutdown;
    end
  end

  // Steering update: immediate or held until the period restarts.
  // Pending value is simply the stored register, so the latest write before the period start cycle wins.
  always_comb begin
    next_state        = state;
    next_active_steer = active_steer;
    case (state)
      ST_IDLE: begin
        if (wr_steer) begin
          if (dat_i[STEER_SYNC_BIT]) begin
            next_state = ST_PENDING;                     // R03
          end else begin
            next_active_steer = dat_i[3:0];              // R01 R02
          end
        end
      end
      ST_PENDING: begin
        if (wr_steer && !dat_i[STEER_SYNC_BIT]) begin
          next_active_steer = dat_i[3:0];                // R01
          next_state        = ST_IDLE;
        end else if (period_start) begin
          next_active_steer = steering_control[3:0];     // R10 R04
          next_state        = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      active_steer <= RST_STEERING_CONTROL[3:0];
    end else begin
      state        <= next_state;
      active_steer <= next_active_steer;
    end
  end

  // Read mux and ack; unmapped addresses ack with zero data
  always_comb begin
    next_ack = cyc_i && stb_i && !ack;
    next_dat = 32'h0000_0000;
    case (adr_i)
      ADDR_CCP_CONTROL:      next_dat[7:0] = ccp_control;
      ADDR_AUTO_SHUTDOWN:    next_dat[7:0] = {shutdown, auto_shutdown_control[6:0]};
      ADDR_TIMER2_PERIOD:    next_dat[7:0] = timer2_period;
      ADDR_STEERING_CONTROL: next_dat[7:0] = steering_control & MASK_STEERING_CONTROL; // R05
      ADDR_RESTART_DELAY:    next_dat[7:0] = pwm_restart_delay_control;
      ADDR_TIMER2_CONTROL:   next_dat[7:0] = timer2_control & MASK_TIMER2_CONTROL;     // R05
      ADDR_TIMER2_COUNT:     next_dat[7:0] = timer2_count_count;
      default:               next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack   <= next_ack;
      dat_o <= next_dat;
    end
  end

  assign ack_o = ack;

  pst_timer2 u_timer2 (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_i          (timer2_control[TIMER2_COUNT_ON_BIT]),
    .presc_sel_i    (timer2_control[TIMER2_COUNT_PRESC_LSB +: 2]),
    .period_i       (timer2_period),
    .load_i         (wr_timer2_count),
    .load_val_i     (dat_i[7:0]),
    .count_o        (timer2_count_count),
    .period_start_o (period_start)
  );

  // Polarity bit 0 for A/C, bit 1 for B/D: set bit = active-low pair
  pst_pin_mux #(
    .PINS (4)
  ) u_pins (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .pwm_i        (pwm_i),
    .steer_i      (steer_enable ? active_steer : 4'h0),  // R07 R06
    .invert_i     ({mode_field[1], mode_field[0], mode_field[1], mode_field[0]}), // R08
    .shutdown_i   (shutdown),                            // R09
    .shut_level_i ({auto_shutdown_control[3], auto_shutdown_control[1],
                    auto_shutdown_control[3], auto_shutdown_control[1]}),
    .shut_tri_i   ({auto_shutdown_control[2], auto_shutdown_control[0],
                    auto_shutdown_control[2], auto_shutdown_control[0]}),
    .port_data_i  (port_data_i),
    .pin_o        (pin_vec),
    .pin_drv_o    (pin_drv_o)
  );

  assign pwm_out_a_o    = pin_vec[0];
  assign pwm_out_b_o    = pin_vec[1];
  assign pwm_out_c_o    = pin_vec[2];
  assign pwm_out_d_o    = pin_vec[3];
  assign period_start_o = period_start;
  assign steer_active_o = steer_enable;

endmodule

// file: tb/pst_steering_properties.sv
// Checker: bus, steering, polarity and shutdown relations at the top ports
`timescale 1ns/1ns
module pst_steering_chk
  import pst_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        pwm_i,
  input wire logic        shutdown_req_i,
  input wire logic        pwm_out_a_o,
  input wire logic        pwm_out_b_o,
  input wire logic [3:0]  pin_drv_o,
  input wire logic        period_start_o,
  input wire logic        steer_active_o
);
  logic       wr;
  logic       rd_st;
  logic       shut_seen;
  logic [7:0] steer_sh;
  logic [7:0] ccp_sh;
  logic [7:0] sd_sh;
  assign wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  // Shadows taken at the write edge; shutdown seen stays until cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_sh  <= RST_STEERING_CONTROL;
      ccp_sh    <= RST_CCP_CONTROL;
      sd_sh     <= RST_AUTO_SHUTDOWN;
      shut_seen <= 1'b0;
      rd_st     <= 1'b0;
    end else begin
      rd_st <= cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_STEERING_CONTROL;
      if (shutdown_req_i) begin
        shut_seen <= 1'b1;
      end else if (wr && adr_i == ADDR_AUTO_SHUTDOWN && !dat_i[7]) begin
        shut_seen <= 1'b0;
      end
      if (wr && adr_i == ADDR_STEERING_CONTROL) begin
        steer_sh <= dat_i[7:0] & MASK_STEERING_CONTROL;
      end
      if (wr && adr_i == ADDR_CCP_CONTROL) begin
        ccp_sh <= dat_i[7:0];
      end
      if (wr && adr_i == ADDR_AUTO_SHUTDOWN) begin
        sd_sh <= dat_i[7:0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse one cycle after request");
  chk_immediate_steer: assert property (
    wr && adr_i == ADDR_STEERING_CONTROL && !dat_i[STEER_SYNC_BIT] && steer_active_o
    |-> ##3 pin_drv_o == steer_sh[3:0]) else $error("immediate steering not applied");
  chk_sync_whole_period: assert property (
    $changed(pin_drv_o) && steer_sh[STEER_SYNC_BIT] && steer_active_o == $past(steer_active_o, 3)
    |-> $past(period_start_o, 2)) else $error("synced steering changed off period start");
  chk_pending_load: assert property (
    period_start_o && steer_active_o |-> ##2 pin_drv_o == $past(steer_sh[3:0], 2))
    else $error("pending steering not loaded at period start");
  chk_reserved_zero: assert property (ack_o && rd_st |-> dat_o[31:5] == 27'h0)
    else $error("reserved steering bits not zero");
  chk_mode_gate: assert property (wr && adr_i == ADDR_CCP_CONTROL
    |=> steer_active_o == (ccp_sh[3:2] == MODE_PWM_HI && ccp_sh[7:6] == CONFIG_SINGLE))
    else $error("steering active flag wrong for mode");
  chk_inactive_no_drive: assert property (!steer_active_o [*3] |-> pin_drv_o == 4'h0)
    else $error("pin driven while steering inactive");
  chk_polarity_a: assert property (
    pin_drv_o[0] && !shut_seen && !$past(shut_seen) && ccp_sh == $past(ccp_sh, 3)
    |-> pwm_out_a_o == ($past(pwm_i) ^ ccp_sh[0])) else $error("pin a level wrong");
  chk_shutdown_steered: assert property (
    shutdown_req_i [*6] && steer_active_o |-> pin_drv_o == steer_sh[3:0]
    && (!pin_drv_o[1] || pwm_out_b_o == sd_sh[3])) else $error("shutdown pin state wrong");
endmodule

bind pst_steering pst_steering_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pwm_i(pwm_i), .shutdown_req_i(shutdown_req_i), .pwm_out_a_o(pwm_out_a_o),
  .pwm_out_b_o(pwm_out_b_o), .pin_drv_o(pin_drv_o), .period_start_o(period_start_o),
  .steer_active_o(steer_active_o));

// file: tb/pst_load_model.sv
// Load model: four pin loads, each with a pull-down
`timescale 1ns/1ns
module pst_load_model (
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] drv_i,
  output logic      [3:0] level_o
);
  // A released pin falls to the pull-down, never keeps its last level
  assign level_o = pin_i & drv_i;
endmodule

// file: tb/testbench.sv
// Testbench: registers, steering timing, polarity and shutdown
`timescale 1ns/1ns
module testbench
  import pst_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pwm = 1'b0;
  logic        sd_req = 1'b0;
  logic [3:0]  pa;
  logic [3:0]  drv;
  logic [3:0]  level;
  logic        pstart;
  logic        sact;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  pst_steering u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pwm_i(pwm),
    .shutdown_req_i(sd_req), .port_data_i(4'h5), .pwm_out_a_o(pa[0]), .pwm_out_b_o(pa[1]),
    .pwm_out_c_o(pa[2]), .pwm_out_d_o(pa[3]), .pin_drv_o(drv), .period_start_o(pstart),
    .steer_active_o(sact));
  pst_load_model u_load (.pin_i(pa), .drv_i(drv), .level_o(level));
  // 125 MHz clock and a hang guard
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; request held until ack is sampled high, only the hang guard ends a wait
  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 8'h00, q);
    check_reg(q, {24'h0, e});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic t_regs;
    rd(ADDR_CCP_CONTROL, RST_CCP_CONTROL);
    rd(ADDR_AUTO_SHUTDOWN, RST_AUTO_SHUTDOWN);
    rd(ADDR_TIMER2_PERIOD, RST_TIMER2_PERIOD);
    rd(ADDR_STEERING_CONTROL, RST_STEERING_CONTROL);
    rd(ADDR_RESTART_DELAY, RST_RESTART_DELAY);
    rd(ADDR_TIMER2_CONTROL, RST_TIMER2_CONTROL);
    rd(ADDR_TIMER2_COUNT, RST_TIMER2_COUNT);
    rd(5'h1C, 8'h00);
    wr(ADDR_STEERING_CONTROL, 8'hE1);
    rd(ADDR_STEERING_CONTROL, 8'h01);
    wr(ADDR_TIMER2_CONTROL, 8'h80);
    rd(ADDR_TIMER2_CONTROL, 8'h00);
    $display("registers done");
  endtask
  task automatic t_mode;
    wr(ADDR_CCP_CONTROL, 8'hCC);
    settle(4);
    check_pin({3'h0, sact} | drv, 4'h0);
    wr(ADDR_CCP_CONTROL, 8'h08);
    settle(4);
    check_pin({3'h0, sact} | drv, 4'h0);
    wr(ADDR_CCP_CONTROL, 8'h0C);
    settle(4);
    check_pin({sact, drv[2:0]}, 4'h9);
    $display("mode done");
  endtask
  task automatic t_immediate;
    @(posedge clk_i);
    pwm <= 1'b1;
    wr(ADDR_STEERING_CONTROL, 8'h05);
    settle(3);
    check_pin(drv, 4'h5);
    check_pin(level, 4'h5);
    wr(ADDR_STEERING_CONTROL, 8'h0A);
    settle(3);
    check_pin(level, 4'hA);
    $display("immediate done");
  endtask
  task automatic t_polarity;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(ADDR_CCP_CONTROL, {6'h03, m});
      settle(3);
      check_pin(level, 4'hA & ~{m[1], m[0], m[1], m[0]});
    end
    $display("polarity done");
  endtask
  task automatic t_sync;
    int n;
    wr(ADDR_CCP_CONTROL, 8'h0C);
    wr(ADDR_STEERING_CONTROL, 8'h05);
    wr(ADDR_TIMER2_COUNT, 8'h00);
    wr(ADDR_TIMER2_PERIOD, 8'h09);
    wr(ADDR_STEERING_CONTROL, 8'h11);
    wr(ADDR_STEERING_CONTROL, 8'h1A);
    settle(12);
    check_pin(drv, 4'h5);
    wr(ADDR_TIMER2_CONTROL, 8'h04);
    n = 0;
    while (pstart !== 1'b1 && n < 100) begin
      settle(1);
      n++;
    end
    check_pin(drv, 4'h5);
    settle(2);
    check_pin(drv, 4'hA);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    $display("sync done");
  endtask
  task automatic t_shutdown;
    @(posedge clk_i);
    pwm <= 1'b0;
    wr(ADDR_AUTO_SHUTDOWN, 8'h0A);
    wr(ADDR_STEERING_CONTROL, 8'h02);
    settle(3);
    check_pin(level, 4'h0);
    @(posedge clk_i);
    sd_req <= 1'b1;
    settle(8);
    check_pin(level, 4'h2);
    check_pin(drv, 4'h2);
    rd(ADDR_AUTO_SHUTDOWN, 8'h8A);
    sd_req <= 1'b0;
    settle(4);
    wr(ADDR_AUTO_SHUTDOWN, 8'h0A);
    settle(3);
    check_pin(level, 4'h0);
    $display("shutdown done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_mode;
    t_immediate;
    t_polarity;
    t_sync;
    t_shutdown;
    stop_test;
  end
endmodule
